//--- inc/dcs_pkg.sv
package dcs_pkg;
    // ********************************
    // register map (word aligned byte offsets)
    // ********************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_SRC = 8'h08;
    localparam logic [7:0] OFS_DST = 8'h0c;
    localparam logic [7:0] OFS_CNT = 8'h10;
    localparam logic [7:0] OFS_FC = 8'h14;
    localparam logic [7:0] OFS_HOLD = 8'h18;
    // ********************************
    // control field positions
    // ********************************
    localparam int CB_GO = 0;
    localparam int CB_SINGLE = 1;
    localparam int CB_EXTREQ = 2;
    localparam int CB_BURST = 3;
    localparam int CB_SIDE = 4;
    localparam int CB_SSTEP = 5;
    localparam int CB_DSTEP = 6;
    localparam int CB_SW = 8;
    localparam int CB_DW = 10;
    localparam int CB_FC3 = 12;
    // status bits
    localparam int SB_DONE = 0;
    localparam int SB_EXTDONE = 1;
    localparam int SB_STOP = 2;
    localparam int SB_ERR = 3;
    localparam int SB_BUSY = 4;
    // width encoding: 00 long, 01 byte, 10 word
    localparam logic [1:0] W_LONG = 2'h0;
    localparam logic [1:0] W_BYTE = 2'h1;
    localparam logic [1:0] W_WORD = 2'h2;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    typedef struct packed {
        logic req;
        logic wr;
        logic [31:0] addr;
        logic [3:0] fc;
        logic [1:0] size;
        logic [31:0] wdata;
    } dcs_bus_req_t;

    typedef struct packed {
        logic ackN;
        logic lastN;
        logic lastOe;
    } dcs_hs_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ARB = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b011,
        ST_SINGLE = 3'b100,
        ST_END = 3'b101
    } dcs_state_t;
endpackage : dcs_pkg

//--- hw/dcs_channel.sv
`timescale 1ns/10ps
module dcs_channel
    import dcs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // bus arbitration
    output logic busReqN,
    input wire logic busGrantN,
    // system bus master cycle
    output dcs_pkg::dcs_bus_req_t busOut,
    output logic fcBit3,
    input wire logic busDone,
    input wire logic busErr,
    input wire logic [31:0] busRdata,
    // peripheral handshake
    input wire logic transferRequestN,
    output logic transferAckN,
    input wire logic lastTransferNIn,
    output logic lastTransferNOut,
    output logic lastTransferNOe
);
    import dcs_pkg::*;

    // ********************************
    // functions
    // ********************************
    function automatic logic [2:0] wBytes(input logic [1:0] w);
        unique case (w)
            W_BYTE: wBytes = 3'h1;
            W_WORD: wBytes = 3'h2;
            default: wBytes = 3'h4;
        endcase
    endfunction : wBytes

    function automatic logic [31:0] ptrStep(input logic [1:0] w, input logic en);
        ptrStep = en ? {29'h0, wBytes(w)} : 32'h0;
    endfunction : ptrStep
    function automatic logic [31:0] laneOut(input logic [31:0] h, input logic [2:0] i, n, b);
        laneOut = h >> (8 * (n - 3'h1 - i) * b);
    endfunction : laneOut

    // ********************************
    // registers
    // ********************************
    logic [31:0] ctrl_q, srcPtr_q, dstPtr_q, cnt_q, hold_q;
    logic [7:0] fc_q;
    logic [4:0] stat_q;
    dcs_state_t state_q;
    logic [2:0] done_q, need_q;
    logic reqS1_q, reqS2_q, reqS3_q, lastS1_q, lastS2_q, lastPend_q;
    logic [31:0] prdata_q;
    logic pready_q;
    dcs_bus_req_t bus_q;
    logic busReqN_q, fc3_q, ackN_q, lastN_q, lastOe_q;

    // ********************************
    // decode
    // ********************************
    wire apbWr = psel && penable && pwrite && pready_q;
    wire apbSetup = psel && !penable;
    wire goBit = ctrl_q[CB_GO];
    wire singleMode = ctrl_q[CB_SINGLE];
    wire extReq = ctrl_q[CB_EXTREQ] || singleMode;
    wire burstMode = ctrl_q[CB_BURST];
    wire srcSide = ctrl_q[CB_SIDE];
    wire [1:0] srcW = ctrl_q[CB_SW+:2];
    wire [1:0] dstW = ctrl_q[CB_DW+:2];
    wire reqLevel = !reqS2_q;
    wire reqEdge = !reqS2_q && !reqS3_q; // cycle steal: two low samples after a high one
    logic edgeArm_q;
    wire stealHit = reqEdge && edgeArm_q;
    wire reqSeen = burstMode ? reqLevel : stealHit;
    wire startOk = goBit && (!extReq || reqSeen);
    // operand size is the larger width; long encodes as zero
    wire [2:0] sB = wBytes(srcW);
    wire [2:0] dB = wBytes(dstW);
    wire [2:0] opB = (sB > dB) ? sB : dB;
    wire [2:0] rdCycles = opB / sB;
    wire [2:0] wrCycles = opB / dB;
    wire [31:0] opB32 = {29'h0, opB};
    wire cycEnd = busDone || busErr;
    wire hsRead = singleMode ? srcSide : srcSide;
    wire finalOp = (cnt_q <= opB32) || lastPend_q;
    wire [31:0] cntNext = (cnt_q > opB32) ? cnt_q - opB32 : 32'h0;
    wire [31:0] holdNext = (sB == 3'h4) ? busRdata :
        (sB == 3'h2) ? {hold_q[15:0], busRdata[15:0]} : {hold_q[23:0], busRdata[7:0]};
    logic [31:0] rdSel;

    always_comb begin
        unique case (paddr)
            OFS_CTRL: rdSel = ctrl_q;
            OFS_STAT: rdSel = {27'h0, stat_q};
            OFS_SRC: rdSel = srcPtr_q;
            OFS_DST: rdSel = dstPtr_q;
            OFS_CNT: rdSel = cnt_q;
            OFS_FC: rdSel = {24'h0, fc_q};
            OFS_HOLD: rdSel = hold_q;
            default: rdSel = 32'h0;
        endcase
    end

    // ********************************
    // input synchronisers
    // ********************************
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            {reqS1_q, reqS2_q, reqS3_q, lastS1_q, lastS2_q} <= 5'h1f;
            edgeArm_q <= 1'b0;
        end else begin
            reqS1_q <= transferRequestN;
            reqS2_q <= reqS1_q;
            reqS3_q <= reqS2_q;
            lastS1_q <= lastTransferNIn;
            lastS2_q <= lastS1_q;
            if (reqS2_q) // re-armed by a high sample; ignored until the channel answers
                edgeArm_q <= 1'b1;
            else if (stealHit && state_q == ST_IDLE)
                edgeArm_q <= 1'b0;
        end
    end

    // ********************************
    // apb slave, zero wait
    // ********************************
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= apbSetup;
            if (apbSetup)
                prdata_q <= rdSel;
        end
    end

    // ********************************
    // sequencer
    // ********************************
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            ctrl_q <= CTRL_RST;
            stat_q <= 5'h0;
            srcPtr_q <= 32'h0;
            dstPtr_q <= 32'h0;
            cnt_q <= 32'h0;
            fc_q <= 8'h0;
            hold_q <= 32'h0;
            done_q <= 3'h0;
            need_q <= 3'h0;
            lastPend_q <= 1'b0;
            bus_q <= '0;
            busReqN_q <= 1'b1;
            fc3_q <= 1'b0;
            ackN_q <= 1'b1;
            lastN_q <= 1'b1;
            lastOe_q <= 1'b0;
        end else begin
            if (apbWr) begin
                unique case (paddr)
                    OFS_CTRL: ctrl_q <= pwdata;
                    OFS_STAT: stat_q <= stat_q & ~pwdata[4:0];
                    OFS_SRC: srcPtr_q <= pwdata;
                    OFS_DST: dstPtr_q <= pwdata;
                    OFS_CNT: cnt_q <= pwdata;
                    OFS_FC: fc_q <= pwdata[7:0];
                    default: ;
                endcase
            end
            // peripheral done during any transfer cycle makes the operand in progress the last
            if (bus_q.req && !lastS2_q)
                lastPend_q <= 1'b1;
            unique case (state_q)
                ST_IDLE: begin
                    stat_q[SB_BUSY] <= 1'b0;
                    if (startOk && cnt_q != 32'h0) begin
                        busReqN_q <= 1'b0;
                        stat_q[SB_BUSY] <= 1'b1;
                        state_q <= ST_ARB;
                    end
                end
                ST_ARB: begin
                    if (!busGrantN) begin
                        done_q <= 3'h0;
                        bus_q.req <= 1'b1;
                        if (singleMode) begin
                            bus_q.wr <= !srcSide;
                            bus_q.addr <= srcSide ? srcPtr_q : dstPtr_q;
                            bus_q.fc <= srcSide ? fc_q[3:0] : fc_q[7:4];
                            bus_q.size <= srcSide ? srcW : dstW;
                            ackN_q <= !extReq;
                            lastN_q <= !(finalOp && extReq);
                            lastOe_q <= finalOp && extReq;
                            state_q <= ST_SINGLE;
                        end else begin
                            bus_q.wr <= 1'b0;
                            bus_q.addr <= srcPtr_q;
                            bus_q.fc <= fc_q[3:0];
                            bus_q.size <= srcW;
                            need_q <= rdCycles;
                            fc3_q <= ctrl_q[CB_FC3];
                            ackN_q <= !(extReq && hsRead);
                            lastN_q <= !(extReq && hsRead && finalOp);
                            lastOe_q <= extReq && hsRead && finalOp;
                            state_q <= ST_READ;
                        end
                    end
                end
                ST_SINGLE: begin
                    if (cycEnd) begin
                        bus_q.req <= 1'b0;
                        ackN_q <= 1'b1;
                        lastN_q <= 1'b1;
                        lastOe_q <= 1'b0;
                        if (srcSide)
                            srcPtr_q <= srcPtr_q + ptrStep(srcW, ctrl_q[CB_SSTEP]);
                        else
                            dstPtr_q <= dstPtr_q + ptrStep(dstW, ctrl_q[CB_DSTEP]);
                        cnt_q <= cntNext;
                        stat_q[SB_ERR] <= busErr;
                        state_q <= ST_END;
                    end
                end
                ST_READ: begin
                    if (cycEnd) begin
                        hold_q <= holdNext;
                        bus_q.addr <= bus_q.addr + {29'h0, sB};
                        done_q <= done_q + 3'h1;
                        if (busErr) begin
                            bus_q.req <= 1'b0;
                            stat_q[SB_ERR] <= 1'b1;
                            state_q <= ST_END;
                        end else if (done_q + 3'h1 == need_q) begin
                            srcPtr_q <= srcPtr_q + (ctrl_q[CB_SSTEP] ? opB32 : 32'h0);
                            done_q <= 3'h0;
                            need_q <= wrCycles;
                            bus_q.wdata <= laneOut(holdNext, 3'h0, wrCycles, dB);
                            bus_q.wr <= 1'b1;
                            bus_q.addr <= dstPtr_q;
                            bus_q.fc <= fc_q[7:4];
                            bus_q.size <= dstW;
                            ackN_q <= !(extReq && !hsRead);
                            lastN_q <= !(extReq && !hsRead && finalOp);
                            lastOe_q <= extReq && !hsRead && finalOp;
                            state_q <= ST_WRITE;
                        end
                    end
                end
                ST_WRITE: begin
                    if (cycEnd) begin
                        bus_q.wdata <= laneOut(hold_q, done_q + 3'h1, wrCycles, dB);
                        bus_q.addr <= bus_q.addr + {29'h0, dB};
                        done_q <= done_q + 3'h1;
                        if (busErr || done_q + 3'h1 == need_q) begin
                            bus_q.req <= 1'b0;
                            fc3_q <= 1'b0;
                            dstPtr_q <= dstPtr_q + (ctrl_q[CB_DSTEP] ? opB32 : 32'h0);
                            cnt_q <= cntNext;
                            stat_q[SB_ERR] <= busErr;
                            state_q <= ST_END;
                        end
                    end
                end
                ST_END: begin
                    ackN_q <= 1'b1;
                    lastN_q <= 1'b1;
                    lastOe_q <= 1'b0;
                    if (stat_q[SB_ERR] || cnt_q == 32'h0 || lastPend_q || !goBit) begin
                        stat_q[SB_DONE] <= !stat_q[SB_ERR] && cnt_q == 32'h0;
                        stat_q[SB_EXTDONE] <= lastPend_q;
                        stat_q[SB_STOP] <= !goBit;
                        ctrl_q[CB_GO] <= 1'b0;
                        lastPend_q <= 1'b0;
                        busReqN_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else if (!extReq || (burstMode && reqLevel)) begin
                        state_q <= ST_ARB;
                    end else begin
                        busReqN_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = 1'b0;
    assign busReqN = busReqN_q;
    assign busOut = bus_q;
    assign fcBit3 = fc3_q;
    assign transferAckN = ackN_q;
    assign lastTransferNOut = lastN_q;
    assign lastTransferNOe = lastOe_q;

    // ********************************
    // checks
    // ********************************
    AST_NO_CYCLE_WITHOUT_GRANT: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(bus_q.req) |-> $past(!busGrantN) && !busReqN_q)
        else $error("bus cycle began without grant");
    AST_SINGLE_NEEDS_EXT: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state_q == ST_SINGLE) |-> !ackN_q)
        else $error("single cycle without acknowledge");
    AST_SINGLE_SIDE: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state_q == ST_SINGLE && srcSide) |-> !bus_q.wr)
        else $error("source side single cycle not a read");
    AST_SINGLE_DEST: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state_q == ST_SINGLE && !srcSide) |-> bus_q.wr)
        else $error("dest side single cycle not a write");
    AST_SINGLE_ONE: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state_q == ST_SINGLE && cycEnd) |=> state_q == ST_END && !bus_q.req)
        else $error("single transfer took more than one cycle");
    AST_READ_THEN_WRITE: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state_q == ST_WRITE) |-> $past(state_q == ST_READ) || $past(state_q == ST_WRITE))
        else $error("write without preceding read");
    AST_FC3_HELD: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state_q == ST_READ && fc3_q) ##1 (state_q == ST_WRITE) |-> fc3_q)
        else $error("fc3 dropped between read and write");
    AST_IDLE_NO_REQ: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state_q == ST_IDLE && !goBit) |=> busReqN_q)
        else $error("bus requested while stopped");
    AST_DONE_SET: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state_q == ST_END && !stat_q[SB_ERR] && cnt_q == 32'h0) |=> stat_q[SB_DONE])
        else $error("done status missing at zero count");
endmodule : dcs_channel

//--- tb/dcs_peer_model.sv
`timescale 1ns/10ps
// ********************************
// memory, arbiter and handshake monitor
// ********************************
module dcs_peer_model
    import dcs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // arbitration and system bus
    input wire logic busReqN,
    output logic busGrantN,
    input wire dcs_pkg::dcs_bus_req_t busOut,
    input wire logic fcBit3,
    output logic busDone,
    output logic busErr,
    output logic [31:0] busRdata,
    // handshake as the peripheral sees it
    input wire logic transferAckN,
    input wire logic lastTransferNOut,
    input wire logic lastTransferNOe,
    // wait states per bus cycle
    input wire logic [1:0] slowWait
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] lastAddr;
    logic [1:0] waitCnt;
    int nRd = 0, nWr = 0, nAck = 0, nLast = 0, nFc3 = 0;
    assign busErr = 1'b0;
    always @(posedge clk_sys) begin
        busDone <= 1'b0;
        // read lines toggle outside the answer so a stale value never looks valid
        busRdata <= ~busRdata;
        busGrantN <= busReqN | ~nrst;
        if (!nrst) begin
            waitCnt <= 2'h0;
            busRdata <= 32'h0;
        end else if (busOut.req && !busDone) begin
            if (waitCnt != slowWait) begin
                waitCnt <= waitCnt + 2'h1;
            end else begin
                waitCnt <= 2'h0;
                busDone <= 1'b1;
                lastAddr <= busOut.addr;
                nAck <= nAck + int'(!transferAckN);
                nLast <= nLast + int'(lastTransferNOe && !lastTransferNOut);
                nFc3 <= nFc3 + int'(fcBit3);
                if (busOut.wr) begin
                    mem[busOut.addr] = busOut.wdata;
                    nWr <= nWr + 1;
                end else begin
                    busRdata <= mem.exists(busOut.addr) ? mem[busOut.addr] : ~busOut.addr;
                    nRd <= nRd + 1;
                end
            end
        end
    end
endmodule : dcs_peer_model

//--- tb/dcs_channel_tb.sv
`timescale 1ns/10ps
module dcs_channel_tb;
    import dcs_pkg::*;
    // ********************************
    // signals
    // ********************************
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, busRdata;
    logic pready, pslverr, busReqN, busGrantN, fcBit3, busDone, busErr;
    logic transferRequestN = 1'b1, lastTransferNIn = 1'b1, transferAckN, lastTransferNOut, lastTransferNOe;
    logic [1:0] slowWait = 2'h0;
    logic [31:0] seed = 32'h1258;
    logic [5:0] cases [6] = '{{W_LONG, W_LONG, 2'b11}, {W_BYTE, W_BYTE, 2'b10}, {W_WORD, W_WORD, 2'b01},
        {W_LONG, W_BYTE, 2'b11}, {W_BYTE, W_LONG, 2'b11}, {W_WORD, W_LONG, 2'b00}};
    dcs_bus_req_t busOut;
    int nErrors = 0, testsRun = 0;
    always #5 clk_sys = ~clk_sys;
    dcs_channel i_dcs_channel (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busReqN(busReqN), .busGrantN(busGrantN), .busOut(busOut), .fcBit3(fcBit3),
        .busDone(busDone), .busErr(busErr), .busRdata(busRdata), .transferRequestN(transferRequestN),
        .transferAckN(transferAckN), .lastTransferNIn(lastTransferNIn), .lastTransferNOut(lastTransferNOut),
        .lastTransferNOe(lastTransferNOe));
    dcs_peer_model i_dcs_peer_model (.clk_sys(clk_sys), .nrst(nrst), .busReqN(busReqN),
        .busGrantN(busGrantN), .busOut(busOut), .fcBit3(fcBit3), .busDone(busDone), .busErr(busErr),
        .busRdata(busRdata), .transferAckN(transferAckN), .lastTransferNOut(lastTransferNOut),
        .lastTransferNOe(lastTransferNOe), .slowWait(slowWait));
    // ********************************
    // helpers
    // ********************************
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic int wb(input logic [1:0] w);
        return (w == W_BYTE) ? 1 : (w == W_WORD) ? 2 : 4;
    endfunction : wb
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nErrors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // the watchdog, not a cycle count, ends a slave that never answers
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(what, r, exp);
    endtask : rdChk
    task automatic finishRun(input logic [31:0] ctl, input logic [31:0] st);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 400 && !r[SB_DONE] && !r[SB_EXTDONE]; i++) apb(1'b0, OFS_STAT, 32'h0, r);
        rdChk("status", OFS_STAT, st);
        rdChk("ctrl", OFS_CTRL, ctl & ~32'h1);
        wr(OFS_STAT, 32'h1f);
        rdChk("status clr", OFS_STAT, 32'h0);
    endtask : finishRun
    // ********************************
    // scenarios
    // ********************************
    task automatic runDual(input logic [1:0] sw, input logic [1:0] dw, input logic ss, input logic ds);
        int sb, db, nb, r0, w0, f0;
        logic [31:0] src, dst, ctl;
        sb = wb(sw);
        db = wb(dw);
        nb = ((sb > db) ? sb : db) * (1 + int'(rnd() % 3));
        src = (rnd() & 32'h0000_fff0) | 32'h0001_0000;
        dst = (rnd() & 32'h0000_fff0) | 32'h0002_0000;
        for (int i = 0; i < nb; i += 4) i_dcs_peer_model.mem[src + 32'(i)] = rnd();
        r0 = i_dcs_peer_model.nRd;
        w0 = i_dcs_peer_model.nWr;
        f0 = i_dcs_peer_model.nFc3;
        slowWait <= 2'(rnd());
        ctl = (32'(ss) << CB_SSTEP) | (32'(ds) << CB_DSTEP) | (32'(sw) << CB_SW) | (32'(dw) << CB_DW);
        ctl = ctl | (32'(ss) << CB_FC3) | 32'h1;
        wr(OFS_SRC, src);
        wr(OFS_DST, dst);
        wr(OFS_CNT, 32'(nb));
        wr(OFS_FC, rnd() & 32'hff);
        wr(OFS_CTRL, ctl);
        finishRun(ctl, 32'h1 << SB_DONE);
        rdChk("src", OFS_SRC, src + (ss ? 32'(nb) : 32'h0));
        rdChk("dst", OFS_DST, dst + (ds ? 32'(nb) : 32'h0));
        rdChk("count", OFS_CNT, 32'h0);
        chk("reads", 32'(i_dcs_peer_model.nRd - r0), 32'(nb / sb));
        chk("writes", 32'(i_dcs_peer_model.nWr - w0), 32'(nb / db));
        chk("fc3", 32'(i_dcs_peer_model.nFc3 - f0), ss ? 32'(nb / sb + nb / db) : 32'h0);
        if (sb == 4 && db == 4 && ss && ds) begin
            for (int i = 0; i < nb; i += 4) begin
                chk("data", i_dcs_peer_model.mem[dst + 32'(i)], i_dcs_peer_model.mem[src + 32'(i)]);
            end
        end
    endtask : runDual
    task automatic runSingle(input logic side, input logic burst);
        int r0, w0, a0, l0;
        logic [31:0] src, dst, ctl;
        src = (rnd() & 32'h0000_fff0) | 32'h0003_0000;
        dst = (rnd() & 32'h0000_fff0) | 32'h0004_0000;
        r0 = i_dcs_peer_model.nRd;
        w0 = i_dcs_peer_model.nWr;
        a0 = i_dcs_peer_model.nAck;
        l0 = i_dcs_peer_model.nLast;
        ctl = 32'h7 | (32'(side) << CB_SIDE) | (32'h3 << CB_SSTEP) | (32'(W_BYTE) << CB_SW);
        ctl = ctl | (32'(W_BYTE) << CB_DW) | (32'(burst) << CB_BURST);
        wr(OFS_SRC, src);
        wr(OFS_DST, dst);
        wr(OFS_CNT, 32'h2);
        wr(OFS_CTRL, ctl);
        repeat (20) @(posedge clk_sys);
        chk("idle request", 32'(busReqN), 32'h1);
        for (int k = 1; k <= 2; k++) begin
            // without burst the pulse spans three samples, longer than the two the edge detector needs; burst holds it low
            transferRequestN <= 1'b0;
            repeat (3) @(posedge clk_sys);
            transferRequestN <= !burst;
            for (int i = 0; i < 200 && i_dcs_peer_model.nAck < a0 + k; i++) @(posedge clk_sys);
        end
        transferRequestN <= 1'b1;
        finishRun(ctl, 32'h1 << SB_DONE);
        chk("single reads", 32'(i_dcs_peer_model.nRd - r0), side ? 32'h2 : 32'h0);
        chk("single writes", 32'(i_dcs_peer_model.nWr - w0), side ? 32'h0 : 32'h2);
        chk("acks", 32'(i_dcs_peer_model.nAck - a0), 32'h2);
        chk("done out", 32'(i_dcs_peer_model.nLast - l0), 32'h1);
        chk("last addr", i_dcs_peer_model.lastAddr, (side ? src : dst) + 32'h1);
    endtask : runSingle
    task automatic runLast();
        int r0;
        logic [31:0] ctl;
        r0 = i_dcs_peer_model.nRd;
        ctl = 32'h1 | (32'h3 << CB_SSTEP);
        lastTransferNIn <= 1'b0;
        wr(OFS_CNT, 32'hc);
        wr(OFS_CTRL, ctl);
        finishRun(ctl, 32'h1 << SB_EXTDONE);
        lastTransferNIn <= 1'b1;
        rdChk("count last", OFS_CNT, 32'h8);
        chk("reads last", 32'(i_dcs_peer_model.nRd - r0), 32'h1);
    endtask : runLast
    task automatic conclude();
        $display("checks %0d errors %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (60000) @(posedge clk_sys);
        nErrors++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        rdChk("ctrl reset", OFS_CTRL, CTRL_RST);
        rdChk("unmapped", 8'hfc, 32'h0);
        for (int k = 0; k < 6; k++) runDual(cases[k][5:4], cases[k][3:2], cases[k][1], cases[k][0]);
        runSingle(1'b1, 1'b0);
        runSingle(1'b0, 1'b1);
        runLast();
        conclude();
    end
endmodule : dcs_channel_tb
